/* File: rtl/uim_top.v */
// serial port interrupt sources, register file and character path
`include "uim_regs.vh"
module uim_top #(
    parameter DEPTH = 16,
    parameter AW = 4,
    parameter TO_W = 32
) (
    // clock and reset
    input wire clk_sys_i,
    input wire reset_n_i,
    // register port
    input wire [31:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output wire [31:0] rdata_o,
    // receiver side
    input wire rx_valid_i,
    input wire [7:0] rx_char_i,
    input wire rx_frame_err_i,
    input wire rx_parity_err_i,
    input wire rx_break_i,
    input wire rx_start_bit_i,
    input wire rx_bit_tick_i,
    // transmitter side
    output wire tx_valid_o,
    output wire [7:0] tx_char_o,
    input wire tx_done_i,
    // interrupt
    output wire irq_o
);
    localparam NREG = 14;

    function [7:0] reg_off;
        input integer k;
        begin
            case (k)
                `UIM_IX_TIMEOUT: reg_off = `UIM_OFF_TIMEOUT;
                `UIM_IX_RXLCR: reg_off = `UIM_OFF_RXLCR;
                `UIM_IX_BAUDI: reg_off = `UIM_OFF_BAUDI;
                `UIM_IX_BAUDF: reg_off = `UIM_OFF_BAUDF;
                `UIM_IX_TXLCR: reg_off = `UIM_OFF_TXLCR;
                `UIM_IX_CTRL: reg_off = `UIM_OFF_CTRL;
                `UIM_IX_LVL: reg_off = `UIM_OFF_LVL;
                `UIM_IX_MASK: reg_off = `UIM_OFF_MASK;
                `UIM_IX_DMA: reg_off = `UIM_OFF_DMA;
                `UIM_IX_XF: reg_off = `UIM_OFF_XF;
                `UIM_IX_RES1: reg_off = `UIM_OFF_RES1;
                `UIM_IX_RES2: reg_off = `UIM_OFF_RES2;
                `UIM_IX_STOP1: reg_off = `UIM_OFF_STOP1;
                default: reg_off = `UIM_OFF_STOP2;
            endcase
        end
    endfunction

    function [31:0] reg_rst;
        input integer k;
        begin
            case (k)
                `UIM_IX_TIMEOUT: reg_rst = `UIM_RST_TIMEOUT;
                `UIM_IX_CTRL: reg_rst = `UIM_RST_CTRL;
                `UIM_IX_LVL: reg_rst = `UIM_RST_LVL;
                default: reg_rst = 32'h0000_0000;
            endcase
        end
    endfunction

    // watermark as a fraction of depth: 1/8, 1/4, 1/2, 3/4, 7/8
    function [AW:0] wmark;
        input [2:0] code;
        reg [31:0] t;
        begin
            case (code)
                3'h0: t = DEPTH / 8;
                3'h1: t = DEPTH / 4;
                3'h2: t = DEPTH / 2;
                3'h3: t = (3 * DEPTH) / 4;
                3'h4: t = (7 * DEPTH) / 8;
                default: t = DEPTH / 2;
            endcase
            wmark = t[AW:0];
        end
    endfunction

    // address decode
    wire in_block = (addr_i & `UIM_BLOCK_MASK) == `UIM_BASE_ADDR;
    wire aligned = addr_i[1:0] == 2'h0;
    wire [7:0] off = addr_i[7:0];
    wire wr_hit = wr_i & in_block & aligned;
    wire rd_hit = rd_i & in_block & aligned;
    wire wr_data = wr_hit & (off == `UIM_OFF_DATA);
    wire rd_data = rd_hit & (off == `UIM_OFF_DATA);
    wire wr_ecr = wr_hit & (off == `UIM_OFF_RSR);
    wire [11:0] iclr = (wr_hit && off == `UIM_OFF_ICLR) ? wdata_i[11:0] : 12'h000;

    // plain read/write registers
    wire [NREG*32-1:0] cfg_bus;
    genvar g;
    generate
        for (g = 0; g < NREG; g = g + 1) begin : cfg_e
            reg [31:0] val_reg;
            always @(posedge clk_sys_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    val_reg <= reg_rst(g);
                end else if (wr_hit && off == reg_off(g)) begin
                    val_reg <= wdata_i;
                end
            end
            assign cfg_bus[g*32 +: 32] = val_reg;
        end
    endgenerate

    wire [31:0] timeout_val = cfg_bus[`UIM_IX_TIMEOUT*32 +: 32];
    wire [31:0] rx_lcr = cfg_bus[`UIM_IX_RXLCR*32 +: 32];
    wire [31:0] tx_lcr = cfg_bus[`UIM_IX_TXLCR*32 +: 32];
    wire [31:0] ctrl = cfg_bus[`UIM_IX_CTRL*32 +: 32];
    wire [31:0] lvl = cfg_bus[`UIM_IX_LVL*32 +: 32];
    wire [31:0] mask_val = cfg_bus[`UIM_IX_MASK*32 +: 32];
    wire [31:0] xf = cfg_bus[`UIM_IX_XF*32 +: 32];
    wire [31:0] stop1 = cfg_bus[`UIM_IX_STOP1*32 +: 32];
    wire [31:0] stop2 = cfg_bus[`UIM_IX_STOP2*32 +: 32];

    wire uart_en = ctrl[`UIM_CTL_UART_EN];
    wire rx_fifo_en = rx_lcr[`UIM_LCR_FIFO_EN];
    wire tx_fifo_en = tx_lcr[`UIM_LCR_FIFO_EN];
    wire [AW:0] rx_wm = wmark(lvl[`UIM_LVL_RX_LO +: 3]);
    wire [AW:0] tx_wm = wmark(lvl[`UIM_LVL_TX_LO +: 3]);

    // stop-character detection
    reg seq_reg;
    wire special_char_detect_en = xf[`UIM_XF_SPECIAL_CHAR_DETECT_EN];
    wire sw_en = xf[`UIM_XF_SW_EN] & ~special_char_detect_en;
    wire [1:0] rx_mode = xf[`UIM_XF_MODE_LO +: 2];
    wire rx_ok = rx_valid_i & uart_en & ctrl[`UIM_CTL_RX_EN];
    wire match1 = rx_char_i == stop1[7:0];
    wire match2 = rx_char_i == stop2[7:0];
    wire sw_hit = sw_en & (((rx_mode == 2'b01) & match1) |
                           ((rx_mode == 2'b10) & match2) |
                           ((rx_mode == 2'b11) & match2 & seq_reg));
    wire special_hit = special_char_detect_en & match2;
    wire stop_hit = rx_ok & (sw_hit | special_hit);
    // flow-control stop characters stay out of the fifo; special ones go in
    wire rx_keep = rx_ok & ~sw_hit;

    // receive fifo
    wire [10:0] rx_head;
    wire [AW:0] rx_fill;
    wire rx_full;
    wire rx_empty;
    wire rx_push = rx_keep & ~rx_full;
    wire overrun = rx_keep & rx_full;
    wire rx_pop = rd_data & ~rx_empty;

    uim_fifo #(
        .WIDTH(11),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_rx_fifo (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .fifo_en_i(rx_fifo_en),
        .push_i(rx_push),
        .data_i({rx_break_i, rx_parity_err_i, rx_frame_err_i, rx_char_i}),
        .pop_i(rx_pop),
        .head_o(rx_head),
        .fill_o(rx_fill),
        .full_o(rx_full),
        .empty_o(rx_empty)
    );

    // transmit fifo and holding register
    wire [7:0] tx_head;
    wire [AW:0] tx_fill;
    wire tx_full;
    wire tx_empty;
    reg hold_full_reg;
    reg [7:0] tx_char_reg;
    wire tx_go = uart_en & ctrl[`UIM_CTL_TX_EN];
    wire tx_load = tx_go & ~tx_empty & (~hold_full_reg | tx_done_i);
    // writes to a full fifo are dropped; software checks the flags first
    wire tx_push = wr_data & ~tx_full;

    uim_fifo #(
        .WIDTH(8),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_tx_fifo (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .fifo_en_i(tx_fifo_en),
        .push_i(tx_push),
        .data_i(wdata_i[7:0]),
        .pop_i(tx_load),
        .head_o(tx_head),
        .fill_o(tx_fill),
        .full_o(tx_full),
        .empty_o(tx_empty)
    );

    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hold_full_reg <= 1'b0;
            tx_char_reg <= 8'h00;
            seq_reg <= 1'b0;
        end else begin
            if (tx_load) begin
                hold_full_reg <= 1'b1;
                tx_char_reg <= tx_head;
            end else if (tx_done_i) begin
                hold_full_reg <= 1'b0;
            end
            if (rx_ok) begin
                seq_reg <= match1;
            end
        end
    end
    assign tx_valid_o = hold_full_reg;
    assign tx_char_o = tx_char_reg;

    // receive idle timer
    wire to_expire;
    uim_timeout #(
        .CW(TO_W)
    ) u_timeout (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .run_i(~rx_empty),
        .restart_i(rx_valid_i | rx_start_bit_i),
        .tick_i(rx_bit_tick_i),
        .period_i(timeout_val[TO_W-1:0]),
        .expire_o(to_expire)
    );

    // interrupt sources; a set in the clearing cycle wins
    reg rx_irq_reg;
    reg tx_irq_reg;
    reg to_irq_reg;
    reg fe_irq_reg;
    reg pe_irq_reg;
    reg be_irq_reg;
    reg oe_irq_reg;
    reg xoff_irq_reg;
    reg rx_cond_q_reg;
    reg tx_cond_q_reg;
    reg rx_irq_next;
    reg tx_irq_next;
    reg to_irq_next;
    reg fe_irq_next;
    reg pe_irq_next;
    reg be_irq_next;
    reg oe_irq_next;
    reg xoff_irq_next;
    reg [3:0] rsr_reg;
    reg [3:0] rsr_next;

    wire rx_cond = rx_fifo_en ? (rx_fill >= rx_wm) : ~rx_empty;
    wire tx_cond = tx_fifo_en ? (tx_fill < tx_wm) : tx_empty;
    wire tx_drop = tx_fifo_en ? (tx_fill > tx_wm) : ~tx_empty;
    wire rx_set = rx_cond & ~rx_cond_q_reg;
    wire tx_set = tx_cond & ~tx_cond_q_reg;
    wire err_ok = rx_keep;

    always @* begin
        rx_irq_next = rx_set | (rx_irq_reg & rx_cond & ~iclr[`UIM_IRQ_RX]);
        tx_irq_next = tx_set | (tx_irq_reg & ~tx_drop & ~iclr[`UIM_IRQ_TX]);
        to_irq_next = to_expire | (to_irq_reg & ~rx_empty & ~iclr[`UIM_IRQ_TO]);
        fe_irq_next = (err_ok & rx_frame_err_i) | (fe_irq_reg & ~iclr[`UIM_IRQ_FE]);
        pe_irq_next = (err_ok & rx_parity_err_i) | (pe_irq_reg & ~iclr[`UIM_IRQ_PE]);
        be_irq_next = (err_ok & rx_break_i) | (be_irq_reg & ~iclr[`UIM_IRQ_BE]);
        oe_irq_next = overrun | (oe_irq_reg & ~iclr[`UIM_IRQ_OE]);
        xoff_irq_next = stop_hit | (xoff_irq_reg & ~iclr[`UIM_IRQ_XOFF]);
        rsr_next = rsr_reg;
        if (wr_ecr) begin
            rsr_next = 4'h0;
        end else if (rx_pop) begin
            rsr_next[2:0] = rx_head[10:8];
        end
        if (overrun) begin
            rsr_next[3] = 1'b1;
        end
    end

    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_irq_reg <= 1'b0;
            tx_irq_reg <= 1'b0;
            to_irq_reg <= 1'b0;
            fe_irq_reg <= 1'b0;
            pe_irq_reg <= 1'b0;
            be_irq_reg <= 1'b0;
            oe_irq_reg <= 1'b0;
            xoff_irq_reg <= 1'b0;
            rx_cond_q_reg <= 1'b0;
            // empty after reset counts as already seen, so no spurious edge
            tx_cond_q_reg <= 1'b1;
            rsr_reg <= 4'h0;
        end else begin
            rx_irq_reg <= rx_irq_next;
            tx_irq_reg <= tx_irq_next;
            to_irq_reg <= to_irq_next;
            fe_irq_reg <= fe_irq_next;
            pe_irq_reg <= pe_irq_next;
            be_irq_reg <= be_irq_next;
            oe_irq_reg <= oe_irq_next;
            xoff_irq_reg <= xoff_irq_next;
            rx_cond_q_reg <= rx_cond;
            tx_cond_q_reg <= tx_cond;
            rsr_reg <= rsr_next;
        end
    end

    wire [11:0] raw = {xoff_irq_reg, oe_irq_reg, be_irq_reg, pe_irq_reg, fe_irq_reg,
                       to_irq_reg, tx_irq_reg, rx_irq_reg, 4'h0};
    wire [11:0] masked = raw & mask_val[11:0];
    assign irq_o = |masked;

    wire busy = hold_full_reg | ~tx_empty;
    wire [7:0] flag_bits = {tx_empty, rx_full, tx_full, rx_empty, busy, 3'h0};
    wire [31:0] flags = `UIM_FLAGS_STATIC | {24'h000000, flag_bits};

    // read mux, registered so data stand in the cycle after the strobe
    reg [31:0] rd_mux;
    reg [31:0] rdata_reg;
    integer k;
    always @* begin
        rd_mux = 32'h0000_0000;
        for (k = 0; k < NREG; k = k + 1) begin
            if (off == reg_off(k)) begin
                rd_mux = cfg_bus[k*32 +: 32];
            end
        end
        case (off)
            `UIM_OFF_DATA: rd_mux = rx_empty ? 32'h0000_0000 :
                                    {20'h00000, rsr_reg[3], rx_head};
            `UIM_OFF_RSR: rd_mux = {28'h0000000, rsr_reg};
            `UIM_OFF_FLAGS: rd_mux = flags;
            `UIM_OFF_RAW: rd_mux = {20'h00000, raw};
            `UIM_OFF_MIS: rd_mux = {20'h00000, masked};
            default: rd_mux = rd_mux;
        endcase
    end

    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rd_hit ? rd_mux : 32'h0000_0000;
        end
    end
    assign rdata_o = rdata_reg;
endmodule

/* File: rtl/uim_regs.vh */
// register map, field positions, reset values and indices of the serial port block
// How it works
// - stop-character match raises the stop interrupt
// - special mode: second stop character raises it
// - fifo mode: receive interrupt at watermark fill
// - receive interrupt clears below watermark or software
// - single location: receive interrupt while data held
// - fifo mode: transmit interrupt below watermark fill
// - single location: transmit interrupt while location empty
// - transmit interrupt set by transition, not level
// - bottom location accepts data while holding busy
// - writing bottom clears; holding-only needs software clear
// - receive timeout when data waits past period
// - timeout clears on empty or software clear
// - receive errors raise error interrupts, clearable
// - error clear write wipes receive status flags
// - block decoded at fixed base address
// - timeout period resets to its default
// - fifo level select resets to its default
// - mask bits gate sources onto one output
`ifndef UIM_REGS_VH
`define UIM_REGS_VH
`define UIM_BASE_ADDR 32'h4030_0000
`define UIM_BLOCK_MASK 32'hffff_ff00
`define UIM_OFF_DATA 8'h00
`define UIM_OFF_RSR 8'h04
`define UIM_OFF_TIMEOUT 8'h0c
`define UIM_OFF_FLAGS 8'h18
`define UIM_OFF_RXLCR 8'h1c
`define UIM_OFF_BAUDI 8'h24
`define UIM_OFF_BAUDF 8'h28
`define UIM_OFF_TXLCR 8'h2c
`define UIM_OFF_CTRL 8'h30
`define UIM_OFF_LVL 8'h34
`define UIM_OFF_MASK 8'h38
`define UIM_OFF_RAW 8'h3c
`define UIM_OFF_MIS 8'h40
`define UIM_OFF_ICLR 8'h44
`define UIM_OFF_DMA 8'h48
`define UIM_OFF_XF 8'h50
`define UIM_OFF_RES1 8'h54
`define UIM_OFF_RES2 8'h58
`define UIM_OFF_STOP1 8'h5c
`define UIM_OFF_STOP2 8'h60
`define UIM_RST_TIMEOUT 32'h0000_01ff
`define UIM_RST_CTRL 32'h0004_0300
`define UIM_RST_LVL 32'h0000_0012
`define UIM_FLAGS_STATIC 32'h0000_1e00
`define UIM_IX_TIMEOUT 0
`define UIM_IX_RXLCR 1
`define UIM_IX_BAUDI 2
`define UIM_IX_BAUDF 3
`define UIM_IX_TXLCR 4
`define UIM_IX_CTRL 5
`define UIM_IX_LVL 6
`define UIM_IX_MASK 7
`define UIM_IX_DMA 8
`define UIM_IX_XF 9
`define UIM_IX_RES1 10
`define UIM_IX_RES2 11
`define UIM_IX_STOP1 12
`define UIM_IX_STOP2 13
`define UIM_CTL_UART_EN 0
`define UIM_CTL_TX_EN 8
`define UIM_CTL_RX_EN 9
`define UIM_LCR_FIFO_EN 4
`define UIM_XF_SW_EN 0
`define UIM_XF_SPECIAL_CHAR_DETECT_EN 1
`define UIM_XF_MODE_LO 2
`define UIM_LVL_TX_LO 0
`define UIM_LVL_RX_LO 3
`define UIM_IRQ_RX 4
`define UIM_IRQ_TX 5
`define UIM_IRQ_TO 6
`define UIM_IRQ_FE 7
`define UIM_IRQ_PE 8
`define UIM_IRQ_BE 9
`define UIM_IRQ_OE 10
`define UIM_IRQ_XOFF 11
`endif

/* File: rtl/uim_fifo.v */
// character fifo in flip-flops, one location deep when disabled
module uim_fifo #(
    parameter WIDTH = 11,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // clock and reset
    input wire clk_sys_i,
    input wire reset_n_i,
    // control
    input wire fifo_en_i,
    input wire push_i,
    input wire [WIDTH-1:0] data_i,
    input wire pop_i,
    // state
    output wire [WIDTH-1:0] head_o,
    output wire [AW:0] fill_o,
    output wire full_o,
    output wire empty_o
);
    // pointers wrap naturally, so depth must be a power of two
    localparam [AW:0] DEPTH_W = DEPTH;
    localparam [AW:0] ONE_W = 1;
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] fill_reg;
    wire do_push = push_i & ~full_o;
    wire do_pop = pop_i & ~empty_o;
    assign full_o = fifo_en_i ? (fill_reg >= DEPTH_W) : (fill_reg >= ONE_W);
    assign empty_o = fill_reg == {(AW+1){1'b0}};
    assign fill_o = fill_reg;
    assign head_o = mem[rd_ptr_reg];
    always @(posedge clk_sys_i) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= data_i;
        end
    end
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            fill_reg <= {(AW+1){1'b0}};
        end else begin
            if (do_push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (do_push && !do_pop) begin
                fill_reg <= fill_reg + ONE_W;
            end else if (do_pop && !do_push) begin
                fill_reg <= fill_reg - ONE_W;
            end
        end
    end
endmodule

/* File: rtl/uim_timeout.v */
// receive idle timer, one expiry pulse per idle stretch
module uim_timeout #(
    parameter CW = 32
) (
    // clock and reset
    input wire clk_sys_i,
    input wire reset_n_i,
    // control
    input wire run_i,
    input wire restart_i,
    input wire tick_i,
    input wire [CW-1:0] period_i,
    // result
    output wire expire_o
);
    reg [CW-1:0] count_reg;
    reg fired_reg;
    reg expire_reg;
    wire [CW-1:0] count_next = count_reg + 1'b1;
    assign expire_o = expire_reg;
    // a zero period never expires, so software can park the timer
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_reg <= {CW{1'b0}};
            fired_reg <= 1'b0;
            expire_reg <= 1'b0;
        end else begin
            expire_reg <= 1'b0;
            if (!run_i || restart_i) begin
                count_reg <= {CW{1'b0}};
                fired_reg <= 1'b0;
            end else if (tick_i && !fired_reg && period_i != {CW{1'b0}}) begin
                count_reg <= count_next;
                if (count_next == period_i) begin
                    expire_reg <= 1'b1;
                    fired_reg <= 1'b1;
                end
            end
        end
    end
endmodule

/* File: bench/uim_top_properties.sv */
// assertion checker for the serial port interrupt block
module uim_checker (
    // clock and reset
    input wire clk_sys_i,
    input wire reset_n_i,
    // register port
    input wire [31:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [31:0] rdata_o,
    // character side
    input wire rx_valid_i,
    input wire [7:0] rx_char_i,
    input wire rx_frame_err_i,
    input wire tx_valid_o,
    input wire [7:0] tx_char_o,
    input wire tx_done_i,
    input wire irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mask_reg;
    logic [31:0] ctrl_reg;
    logic [31:0] xf_reg;
    logic [31:0] stop2_reg;
    wire hit = (addr_i[31:8] == 24'h403000) && (addr_i[1:0] == 2'h0);
    wire [7:0] off = addr_i[7:0];
    wire rx_on = ctrl_reg[0] && ctrl_reg[9];
    // shadows of written registers
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mask_reg <= 32'h0;
            ctrl_reg <= 32'h0004_0300;
            xf_reg <= 32'h0;
            stop2_reg <= 32'h0;
        end else if (wr_i && hit) begin
            if (off == 8'h38) mask_reg <= wdata_i;
            if (off == 8'h30) ctrl_reg <= wdata_i;
            if (off == 8'h50) xf_reg <= wdata_i;
            if (off == 8'h60) stop2_reg <= wdata_i;
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("stray read data");
    a_outside_zero: assert property (rd_i && !hit |=> rdata_o == 32'h0)
        else $error("outside read data");
    a_iclr_zero: assert property (rd_i && hit && off == 8'h44 |=> rdata_o == 32'h0)
        else $error("clear reg read");
    a_status_bits: assert property (rd_i && hit && (off == 8'h3c || off == 8'h40)
        |=> rdata_o[31:12] == 20'h0 && rdata_o[3:0] == 4'h0)
        else $error("status bits");
    a_flags_fixed: assert property (rd_i && hit && off == 8'h18 |=> rdata_o[12:9] == 4'hf)
        else $error("flag bits");
    a_mis_irq: assert property (rd_i && hit && off == 8'h40
        |=> (rdata_o != 32'h0) == $past(irq_o))
        else $error("masked status");
    a_mask_gate: assert property (mask_reg[11:4] == 8'h0 |-> !irq_o)
        else $error("masked irq");
    a_tx_hold: assert property (tx_valid_o && !tx_done_i |=> tx_valid_o && $stable(tx_char_o))
        else $error("holding changed");
    a_stop_two: assert property (rx_valid_i && rx_on && xf_reg[1] && mask_reg[11]
        && rx_char_i == stop2_reg[7:0] |=> irq_o)
        else $error("special irq");
    a_err_irq: assert property (rx_valid_i && rx_on && rx_frame_err_i && mask_reg[7] |=> irq_o)
        else $error("framing irq");
    c_rx_err: cover property (rx_valid_i && rx_frame_err_i);
    c_tx_done: cover property (tx_valid_o && tx_done_i);
    c_irq_rise: cover property ($rose(irq_o));
endmodule
bind uim_top uim_checker chk (.clk_sys_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .rx_valid_i, .rx_char_i, .rx_frame_err_i, .tx_valid_o, .tx_char_o, .tx_done_i,
    .irq_o);

/* File: bench/uim_remote.sv */
// remote serial transceiver model on the character side of the port
module uim_remote (
    // clock
    input wire clk_sys_i,
    // from the port
    input wire hold_i,
    input wire [7:0] hold_char_i,
    // to the port
    output logic done_o,
    output logic valid_o,
    output logic [7:0] char_o,
    output logic fe_o,
    output logic pe_o,
    output logic brk_o,
    output logic start_o,
    output logic tick_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int delay = 2;
    int sent = 0;
    logic [7:0] last = 8'h0;
    logic [1:0] cnt = 2'h0;
    initial {done_o, valid_o, char_o, fe_o, pe_o, brk_o, start_o} = 14'h0;
    // free-running bit tick
    always @(posedge clk_sys_i) begin
        cnt <= cnt + 2'h1;
        tick_o <= (cnt == 2'h3);
    end
    // line time set by bench
    initial begin
        forever begin
            @(posedge clk_sys_i);
            if (hold_i === 1'b1) begin
                repeat (delay) @(posedge clk_sys_i);
                last = hold_char_i;
                sent++;
                done_o <= 1'b1;
                @(posedge clk_sys_i);
                done_o <= 1'b0;
            end
        end
    end
    task automatic send(input logic [7:0] c, input logic [2:0] err);
        @(posedge clk_sys_i);
        start_o <= 1'b1;
        @(posedge clk_sys_i);
        start_o <= 1'b0;
        valid_o <= 1'b1;
        char_o <= c;
        {brk_o, pe_o, fe_o} <= err;
        @(posedge clk_sys_i);
        valid_o <= 1'b0;
        char_o <= ~c;
        repeat (2) @(posedge clk_sys_i);
    endtask
endmodule

/* File: bench/test_uim_top.sv */
// self-checking bench for the serial port interrupt block
module test_uim_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [31:0] addr_i = 32'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    wire [31:0] rdata_o;
    wire rx_valid, rx_fe, rx_pe, rx_brk, rx_start, rx_tick, tx_valid, tx_done, irq_o;
    wire [7:0] rx_char;
    wire [7:0] tx_char;
    int mismatches = 0;
    int num_checks = 0;
    logic [31:0] v;
    uim_top uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_valid_i(rx_valid),
        .rx_char_i(rx_char), .rx_frame_err_i(rx_fe), .rx_parity_err_i(rx_pe),
        .rx_break_i(rx_brk), .rx_start_bit_i(rx_start), .rx_bit_tick_i(rx_tick),
        .tx_valid_o(tx_valid), .tx_char_o(tx_char), .tx_done_i(tx_done), .irq_o(irq_o));
    uim_remote rem (.clk_sys_i(clk_sys_i), .hold_i(tx_valid), .hold_char_i(tx_char),
        .done_o(tx_done), .valid_o(rx_valid), .char_o(rx_char), .fe_o(rx_fe), .pe_o(rx_pe),
        .brk_o(rx_brk), .start_o(rx_start), .tick_o(rx_tick));
    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // idle edge after each strobe
    task automatic wr(input logic [7:0] off, input logic [31:0] d);
        wr_i <= 1'b1;
        addr_i <= {24'h403000, off};
        wdata_i <= d;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic rd(input logic [31:0] a);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        @(negedge clk_sys_i);
        v = rdata_o;
        @(posedge clk_sys_i);
    endtask
    task automatic rdc(input logic [7:0] off, input logic [31:0] exp);
        rd({24'h403000, off});
        chk($sformatf("reg %h", off), v, exp);
    endtask
    task automatic wait_sent(input int n);
        for (int k = 0; k < 400 && rem.sent < n; k++) @(posedge clk_sys_i);
        chk("sent", rem.sent, n);
    endtask
    task automatic t_reset();
        rdc(8'h0c, 32'h1ff);
        rdc(8'h34, 32'h12);
        rdc(8'h18, 32'h1e90);
        rdc(8'h30, 32'h40300);
        rdc(8'h3c, 32'h0);
        rdc(8'h08, 32'h0);
        rd(32'h4031_000c);
        chk("outside", v, 32'h0);
        wr(8'h18, 32'h0);
        rdc(8'h18, 32'h1e90);
        $display("reset done");
    endtask
    task automatic t_rx_single();
        wr(8'h30, 32'h301);
        wr(8'h0c, 32'h4);
        rem.send(8'h41, 3'h0);
        rdc(8'h3c, 32'h10);
        chk("irq", {31'h0, irq_o}, 32'h0);
        wr(8'h38, 32'h10);
        chk("irq", {31'h0, irq_o}, 32'h1);
        repeat (30) @(posedge clk_sys_i);
        rdc(8'h3c, 32'h50);
        rdc(8'h00, 32'h41);
        rdc(8'h3c, 32'h0);
        wr(8'h38, 32'h7f0);
        rem.send(8'h00, 3'h1);
        rdc(8'h3c, 32'h90);
        rdc(8'h00, 32'h100);
        rdc(8'h04, 32'h1);
        wr(8'h04, 32'h0);
        rdc(8'h04, 32'h0);
        wr(8'h44, 32'h80);
        rdc(8'h3c, 32'h0);
        rem.send(8'h01, 3'h0);
        rem.send(8'h02, 3'h0);
        rdc(8'h3c, 32'h410);
        rdc(8'h04, 32'h8);
        rdc(8'h00, 32'h801);
        wr(8'h04, 32'h0);
        rdc(8'h04, 32'h0);
        wr(8'h44, 32'h7f0);
        $display("rx single done");
    endtask
    task automatic t_rx_fifo();
        wr(8'h1c, 32'h10);
        wr(8'h34, 32'h0);
        rem.send(8'h31, 3'h0);
        rdc(8'h3c, 32'h0);
        rem.send(8'h32, 3'h0);
        rdc(8'h3c, 32'h10);
        wr(8'h44, 32'h10);
        rem.send(8'h33, 3'h0);
        rdc(8'h3c, 32'h0);
        rdc(8'h00, 32'h31);
        rdc(8'h00, 32'h32);
        rem.send(8'h34, 3'h0);
        rdc(8'h3c, 32'h10);
        rdc(8'h00, 32'h33);
        rdc(8'h3c, 32'h0);
        rdc(8'h00, 32'h34);
        $display("rx fifo done");
    endtask
    task automatic t_tx_single();
        rem.delay = 20;
        rdc(8'h3c, 32'h0);
        wr(8'h00, 32'h55);
        repeat (4) @(posedge clk_sys_i);
        rdc(8'h3c, 32'h20);
        chk("holding", {23'h0, tx_valid, tx_char}, 32'h155);
        wr(8'h00, 32'h66);
        rdc(8'h3c, 32'h0);
        wait_sent(2);
        chk("last", {24'h0, rem.last}, 32'h66);
        repeat (4) @(posedge clk_sys_i);
        rdc(8'h3c, 32'h20);
        wr(8'h44, 32'h20);
        rdc(8'h3c, 32'h0);
        $display("tx single done");
    endtask
    task automatic t_tx_fifo();
        wr(8'h2c, 32'h10);
        rem.delay = 40;
        for (int i = 1; i <= 4; i++) wr(8'h00, 32'h70 + i);
        rdc(8'h3c, 32'h0);
        wait_sent(4);
        repeat (4) @(posedge clk_sys_i);
        rdc(8'h3c, 32'h20);
        wait_sent(6);
        chk("last", {24'h0, rem.last}, 32'h74);
        wr(8'h44, 32'h20);
        $display("tx fifo done");
    endtask
    task automatic t_stop();
        wr(8'h38, 32'h800);
        wr(8'h60, 32'h13);
        wr(8'h5c, 32'h11);
        wr(8'h50, 32'h2);
        rem.send(8'h13, 3'h0);
        rdc(8'h3c, 32'h800);
        chk("irq", {31'h0, irq_o}, 32'h1);
        rdc(8'h00, 32'h13);
        // mode 3 needs the first stop character just before the second
        for (int m = 1; m <= 3; m++) begin
            wr(8'h44, 32'h800);
            wr(8'h50, 32'h1 | (m << 2));
            if (m == 3) rem.send(8'h11, 3'h0);
            rem.send(m == 1 ? 8'h11 : 8'h13, 3'h0);
            rdc(8'h3c, 32'h800);
            rdc(8'h00, m == 3 ? 32'h11 : 32'h0);
        end
        $display("stop done");
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        @(posedge clk_sys_i);
        t_reset();
        t_rx_single();
        t_rx_fifo();
        t_tx_single();
        t_tx_fifo();
        t_stop();
        stop_test();
    end
    // run needs under 2k cycles
    initial begin
        #200us;
        mismatches++;
        stop_test();
    end
endmodule
